// *** hdl/rss_core.sv ***
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - plain right rotate moves bit 0 to bit 7 and updates only sign and zero.
// - destination bit 0 writes the accumulator except for fill-ones, 1 writes the addressed register.
// - access bit 0 uses the access bank, 1 uses the bank select register.
// - fill-ones loads ff into the register and leaves all flags alone.
// - subtract with borrow computes register minus accumulator minus inverted carry.
// - nibble exchange swaps the halves of the register, flags untouched.
// - table fetch copies the program byte to the latch with four pointer modes.
// - rotate through carry shifts bit 0 into carry and old carry into bit 7.
// - the program byte pointer is 21 bits, bit 0 picks low or high word byte.
module rss_core
#(
   parameter int PTR_W = 21,
   parameter int PROG_WORDS = 256
)
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic busy_out
);
   // ==========================================
   // state
   logic [15:0] opcode_q;
   logic [7:0] acc_q;
   logic [4:0] status_q;
   logic [3:0] bank_q;
   logic [PTR_W-1:0] ptr_q;
   logic [7:0] latch_q;
   logic [7:0] faddr_q;
   logic [7:0] fdata_q;
   logic [7:0] file_mem [0:4095];
   logic [15:0] prog_mem [0:PROG_WORDS-1];
   logic tbl_q;
   logic [PTR_W-1:0] tbl_addr_q;
   logic aw_q;
   logic w_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q;
   logic bvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic rvalid_q;
   // ==========================================
   // operand addressing
   logic [11:0] file_addr;
   logic [7:0] file_rd;
   logic [7:0] alu_res;
   logic [4:0] alu_st;
   logic alu_wr;
   logic go;
   logic wr_fire;
   logic is_tbl;
   logic dest_reg;
   rss_pkg::rss_tbl_mode_t tmode;
   logic [PTR_W-1:0] ptr_pre;
   logic [PTR_W-1:0] rd_addr;
   logic [7:0] prog_byte;
   // access bank: low half to bank 0, high half to top bank
   assign file_addr = opcode_q[8] ? {bank_q, opcode_q[7:0]} :
      (opcode_q[7:0] < 8'(rss_pkg::ACCESS_SPLIT) ? {4'h0, opcode_q[7:0]} :
      {rss_pkg::ACCESS_HI_BANK, opcode_q[7:0]});
   assign file_rd = file_mem[file_addr];
   assign dest_reg = opcode_q[9] | (opcode_q[15:9] == rss_pkg::OP_FILL);
   assign is_tbl = (opcode_q[15:2] == rss_pkg::OP_TBL_RD);
   assign tmode = rss_pkg::rss_tbl_mode_t'(opcode_q[1:0]);
   assign ptr_pre = ptr_q + PTR_W'(1);
   assign rd_addr = (tmode == rss_pkg::RSS_TBL_PREINC) ? ptr_pre : ptr_q;
   // byte select by pointer bit 0
   assign prog_byte = tbl_addr_q[0] ? prog_mem[tbl_addr_q[PTR_W-1:1] % PROG_WORDS][15:8] :
      prog_mem[tbl_addr_q[PTR_W-1:1] % PROG_WORDS][7:0];
   assign wr_fire = aw_q & w_q & ~bvalid_q;
   assign go = wr_fire & (awaddr_q == rss_pkg::ADDR_CTRL) & wdata_q[0] & ~tbl_q;
   assign busy_out = tbl_q;
   rss_alu u_alu
   (
      .opcode_in(opcode_q),
      .file_in(file_rd),
      .acc_in(acc_q),
      .status_in(status_q),
      .result_out(alu_res),
      .status_out(alu_st),
      .writes_out(alu_wr)
   );
   assign s_axi_awready = ~aw_q;
   assign s_axi_wready = ~w_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rvalid = rvalid_q;
   // ==========================================
   // write channel capture and response
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= rss_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && !aw_q)
         begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_q)
         begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q > rss_pkg::ADDR_FILE_DATA || awaddr_q[1:0] != 2'b00) ?
               rss_pkg::RESP_SLVERR : rss_pkg::RESP_OKAY;
         end
         if (bvalid_q && s_axi_bready)
         begin
            bvalid_q <= 1'b0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
         end
      end
   end
   // ==========================================
   // architectural state: software writes, then execution
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         opcode_q <= 16'h0;
         acc_q <= 8'h00;
         status_q <= 5'h00;
         bank_q <= 4'h0;
         ptr_q <= '0;
         latch_q <= 8'h00;
         faddr_q <= 8'h00;
         tbl_q <= 1'b0;
         tbl_addr_q <= '0;
      end
      else
      begin
         if (wr_fire && wstrb_q[0])
         begin
            case (awaddr_q)
               rss_pkg::ADDR_OPCODE: opcode_q <= {wstrb_q[1] ? wdata_q[15:8] :
                  opcode_q[15:8], wdata_q[7:0]};
               rss_pkg::ADDR_ACC: acc_q <= wdata_q[7:0];
               rss_pkg::ADDR_STATUS: status_q <= wdata_q[4:0];
               rss_pkg::ADDR_BANK: bank_q <= wdata_q[3:0];
               rss_pkg::ADDR_PTR: ptr_q <= wdata_q[PTR_W-1:0];
               rss_pkg::ADDR_LATCH: latch_q <= wdata_q[7:0];
               rss_pkg::ADDR_FILE_ADDR: faddr_q <= wdata_q[7:0];
               default: ;
            endcase
         end
         // one-cycle ops, table fetch takes a second cycle
         if (go && is_tbl)
         begin
            tbl_q <= 1'b1;
            tbl_addr_q <= rd_addr;
            case (tmode)
               rss_pkg::RSS_TBL_POSTINC: ptr_q <= ptr_pre;
               rss_pkg::RSS_TBL_POSTDEC: ptr_q <= ptr_q - PTR_W'(1);
               rss_pkg::RSS_TBL_PREINC: ptr_q <= ptr_pre;
               default: ;
            endcase
         end
         else if (go && alu_wr)
         begin
            status_q <= alu_st;
            if (!dest_reg)
            begin
               acc_q <= alu_res;
            end
         end
         if (tbl_q)
         begin
            tbl_q <= 1'b0;
            latch_q <= prog_byte;
         end
      end
   end
   // ==========================================
   // memory writes: file from data port or instruction result, program word from latch port
   always_ff @(posedge clock_in)
   begin
      if (go && !is_tbl && alu_wr && dest_reg)
      begin
         file_mem[file_addr] <= alu_res;
      end
      else if (wr_fire && awaddr_q == rss_pkg::ADDR_FILE_DATA && wstrb_q[0])
      begin
         file_mem[{bank_q, faddr_q}] <= wdata_q[7:0];
      end
      if (wr_fire && awaddr_q == rss_pkg::ADDR_LATCH && wstrb_q[1])
      begin
         prog_mem[ptr_q[PTR_W-1:1] % PROG_WORDS] <= wdata_q[15:0];
      end
   end
   // ==========================================
   // read channel, one cycle after address
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= rss_pkg::RESP_OKAY;
      end
      else if (rvalid_q)
      begin
         if (s_axi_rready)
         begin
            rvalid_q <= 1'b0;
         end
      end
      else if (s_axi_arvalid)
      begin
         rvalid_q <= 1'b1;
         rresp_q <= rss_pkg::RESP_OKAY;
         case (s_axi_araddr)
            rss_pkg::ADDR_CTRL: rdata_q <= {31'h0, tbl_q};
            rss_pkg::ADDR_OPCODE: rdata_q <= {16'h0, opcode_q};
            rss_pkg::ADDR_ACC: rdata_q <= {24'h0, acc_q};
            rss_pkg::ADDR_STATUS: rdata_q <= {27'h0, status_q};
            rss_pkg::ADDR_BANK: rdata_q <= {28'h0, bank_q};
            rss_pkg::ADDR_PTR: rdata_q <= 32'(ptr_q);
            rss_pkg::ADDR_LATCH: rdata_q <= {24'h0, latch_q};
            rss_pkg::ADDR_FILE_ADDR: rdata_q <= {24'h0, faddr_q};
            rss_pkg::ADDR_FILE_DATA: rdata_q <= {24'h0, file_mem[{bank_q, faddr_q}]};
            default:
            begin
               rdata_q <= 32'h0;
               rresp_q <= rss_pkg::RESP_SLVERR;
            end
         endcase
      end
   end
endmodule

// *** hdl/rss_pkg.sv ***
package rss_pkg;
   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_OPCODE = 8'h04;
   localparam logic [7:0] ADDR_ACC = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_BANK = 8'h10;
   localparam logic [7:0] ADDR_PTR = 8'h14;
   localparam logic [7:0] ADDR_LATCH = 8'h18;
   localparam logic [7:0] ADDR_FILE_ADDR = 8'h1c;
   localparam logic [7:0] ADDR_FILE_DATA = 8'h20;
   // ==========================================
   // opcode prefixes (top 6 to 14 bits of 16-bit word)
   localparam logic [5:0] OP_ROT_PLAIN = 6'h10;   // 0100 00
   localparam logic [5:0] OP_ROT_CARRY = 6'h0c;   // 0011 00
   localparam logic [6:0] OP_FILL = 7'h34;        // 0110 100
   localparam logic [5:0] OP_SUB_B = 6'h16;       // 0101 10
   localparam logic [5:0] OP_SWAP = 6'h0e;        // 0011 10
   localparam logic [13:0] OP_TBL_RD = 14'h0002;  // 0000 0000 0000 10
   // status bit positions: c, dc, z, ov, n
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_OV = 3;
   localparam int ST_N = 4;
   localparam int ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {RSS_TBL_NONE, RSS_TBL_POSTINC, RSS_TBL_POSTDEC, RSS_TBL_PREINC}
      rss_tbl_mode_t;
endpackage

// *** hdl/rss_alu.sv ***
`timescale 1ns/1ps
// ==========================================
// combinational result and flag unit
module rss_alu
(
   input wire logic [15:0] opcode_in,
   input wire logic [7:0] file_in,
   input wire logic [7:0] acc_in,
   input wire logic [4:0] status_in,
   output logic [7:0] result_out,
   output logic [4:0] status_out,
   output logic writes_out
);
   logic [8:0] sub_full;
   logic [4:0] sub_low;
   logic [7:0] src;
   logic bw;
   assign src = file_in;
   assign bw = ~status_in[rss_pkg::ST_C];
   // borrow enters as inverted carry
   assign sub_full = {1'b0, src} - {1'b0, acc_in} - {8'h00, bw};
   assign sub_low = {1'b0, src[3:0]} - {1'b0, acc_in[3:0]} - {4'h0, bw};
   // decode by opcode prefix
   always_comb
   begin
      result_out = file_in;
      status_out = status_in;
      writes_out = 1'b0;
      if (opcode_in[15:10] == rss_pkg::OP_ROT_PLAIN)
      begin
         result_out = {file_in[0], file_in[7:1]};
         status_out[rss_pkg::ST_N] = file_in[0];
         status_out[rss_pkg::ST_Z] = (file_in == 8'h00);
         writes_out = 1'b1;
      end
      else if (opcode_in[15:10] == rss_pkg::OP_ROT_CARRY)
      begin
         result_out = {status_in[rss_pkg::ST_C], file_in[7:1]};
         status_out[rss_pkg::ST_C] = file_in[0];
         status_out[rss_pkg::ST_N] = status_in[rss_pkg::ST_C];
         status_out[rss_pkg::ST_Z] = ({status_in[rss_pkg::ST_C], file_in[7:1]} == 8'h00);
         writes_out = 1'b1;
      end
      else if (opcode_in[15:9] == rss_pkg::OP_FILL)
      begin
         result_out = 8'hff;
         writes_out = 1'b1;
      end
      else if (opcode_in[15:10] == rss_pkg::OP_SUB_B)
      begin
         result_out = sub_full[7:0];
         status_out[rss_pkg::ST_C] = ~sub_full[8];
         status_out[rss_pkg::ST_DC] = ~sub_low[4];
         status_out[rss_pkg::ST_Z] = (sub_full[7:0] == 8'h00);
         status_out[rss_pkg::ST_N] = sub_full[7];
         // overflow when operand signs differ and result sign leaves the minuend
         status_out[rss_pkg::ST_OV] = (src[7] ^ acc_in[7]) & (src[7] ^ sub_full[7]);
         writes_out = 1'b1;
      end
      else if (opcode_in[15:10] == rss_pkg::OP_SWAP)
      begin
         result_out = {file_in[3:0], file_in[7:4]};
         writes_out = 1'b1;
      end
   end
endmodule

// *** verification/rss_core_props.sv ***
`timescale 1ns/1ps
// ========
// port timing checks
module rss_chk
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic busy_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);
   logic [15:0] op_q;
   // last opcode written, so a fetch launch can be recognised
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         op_q <= 16'h0000;
      else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == rss_pkg::ADDR_OPCODE)
         op_q <= s_axi_wdata[15:0];
   end
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read response dropped");
   property p_wr_lat;
      s_wr_take |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write response late");
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read response late");
   property p_aw_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("ready while response pending");
   property p_wr_err;
      s_wr_take and s_axi_awaddr == 8'h24 |-> ##[1:2] s_axi_bvalid
         && s_axi_bresp == rss_pkg::RESP_SLVERR;
   endproperty
   a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
   property p_fetch_busy;
      s_wr_take and s_axi_awaddr == rss_pkg::ADDR_CTRL && s_axi_wdata[0]
         && op_q[15:2] == rss_pkg::OP_TBL_RD |-> ##[1:3] busy_out;
   endproperty
   a_fetch_busy: assert property (p_fetch_busy) else $error("fetch without busy");
   property p_busy_one;
      busy_out |=> !busy_out;
   endproperty
   a_busy_one: assert property (p_busy_one) else $error("busy too long");
endmodule
bind rss_core rss_chk u_chk (.clock_in, .sys_rst_in, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .busy_out);

// *** verification/tb_rss_core.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_rss_core;
   // ========
   // bench signals
   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy_out;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rdat;
   logic [15:0] op;
   logic [7:0] rg, ac, st, er, ea, es;
   int failures = 0;
   int num_checks = 0;
   int cyc = 0;
   // opcode, reg, acc, status in, reg, acc, status out
   logic [63:0] tab [10] = '{64'h4220_d700_0beb_001b, 64'h4020_d755_00d7_eb10,
      64'h6820_5a00_1fff_001f, 64'h5a20_190d_010c_0d01, 64'h5820_1b1a_001b_0007,
      64'h5a20_030e_01f5_0e10, 64'h5a20_8001_017f_0109, 64'h3a20_5300_1f35_001f,
      64'h3020_e700_01e7_f311, 64'h4220_0000_0000_0004};
   logic [7:0] tl [4] = '{8'h12, 8'h12, 8'h34, 8'h34};
   logic [20:0] tp [4] = '{21'h0000a6, 21'h0000a7, 21'h0000a6, 21'h0000a7};
   always #25 clock_in = ~clock_in;
   rss_core #(.PTR_W(21), .PROG_WORDS(256)) DUT (.clock_in, .sys_rst_in, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .busy_out);
   // ========
   // verdict and hang guard
   task automatic close_out();
      if (failures == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clock_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         $display("[ERR] %0t bench timeout", $time);
         close_out();
      end
   end
   // ========
   // register port transfers, each starts one edge after the last ended
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
      input int hold = 0);
      int n = 0;
      @(posedge clock_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (hold == 0);
      do
      begin
         @(posedge clock_in);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         n++;
         // late ready makes the response wait, so its hold is exercised
         if (n >= hold && !s_axi_bready)
            s_axi_bready <= 1'b1;
      end
      while (!(s_axi_bvalid && s_axi_bready));
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input int hold = 0);
      int n = 0;
      @(posedge clock_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (hold == 0);
      do
      begin
         @(posedge clock_in);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         n++;
         if (n >= hold && !s_axi_rready)
            s_axi_rready <= 1'b1;
      end
      while (!(s_axi_rvalid && s_axi_rready));
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // file byte access through bank and address registers
   task automatic sel(input logic [3:0] b, input logic [7:0] f);
      wr(rss_pkg::ADDR_BANK, {28'h0, b});
      wr(rss_pkg::ADDR_FILE_ADDR, {24'h0, f});
   endtask
   task automatic run(input logic [15:0] o);
      wr(rss_pkg::ADDR_OPCODE, {16'h0, o});
      wr(rss_pkg::ADDR_CTRL, 32'h1);
   endtask
   // ========
   // main sequence
   initial
   begin
      repeat (10) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      rd(rss_pkg::ADDR_STATUS);
      `CHK(rdat, 32'h0)
      // table of data ops, bank register set away from the access bank
      for (int i = 0; i < 10; i++)
      begin
         {op, rg, ac, st, er, ea, es} = tab[i];
         sel(4'h0, 8'h20);
         wr(rss_pkg::ADDR_FILE_DATA, {24'h0, rg});
         wr(rss_pkg::ADDR_ACC, {24'h0, ac});
         wr(rss_pkg::ADDR_STATUS, {24'h0, st});
         wr(rss_pkg::ADDR_BANK, 32'h5);
         run(op);
         `CHK(resp, rss_pkg::RESP_OKAY)
         sel(4'h0, 8'h20);
         rd(rss_pkg::ADDR_FILE_DATA);
         `CHK(rdat[7:0], er)
         rd(rss_pkg::ADDR_ACC);
         `CHK(rdat[7:0], ea)
         rd(rss_pkg::ADDR_STATUS);
         `CHK(rdat[4:0], es[4:0])
      end
      // banked fill: only the selected bank changes
      sel(4'h0, 8'h20);
      wr(rss_pkg::ADDR_FILE_DATA, 32'h22);
      sel(4'h3, 8'h20);
      wr(rss_pkg::ADDR_FILE_DATA, 32'h11);
      run(16'h6920);
      rd(rss_pkg::ADDR_FILE_DATA);
      `CHK(rdat[7:0], 8'hff)
      sel(4'h0, 8'h20);
      rd(rss_pkg::ADDR_FILE_DATA);
      `CHK(rdat[7:0], 8'h22)
      // table fetch in all four pointer modes over one program word
      wr(rss_pkg::ADDR_PTR, 32'h0000_00a6);
      wr(rss_pkg::ADDR_LATCH, 32'h0000_3412, 4'h3);
      for (int m = 0; m < 4; m++)
      begin
         run(16'h0008 | 16'(m));
         rd(rss_pkg::ADDR_LATCH);
         `CHK(rdat[7:0], tl[m])
         rd(rss_pkg::ADDR_PTR);
         `CHK(rdat[20:0], tp[m])
      end
      // pointer wraps at its full width
      wr(rss_pkg::ADDR_PTR, 32'h001f_ffff);
      run(16'h0009);
      rd(rss_pkg::ADDR_PTR);
      `CHK(rdat[20:0], 21'h000000)
      // unmapped place is refused both ways
      wr(8'h24, 32'h0);
      `CHK(resp, rss_pkg::RESP_SLVERR)
      rd(8'h24);
      `CHK(resp, rss_pkg::RESP_SLVERR)
      // access bank upper half goes to the top bank, bank register ignored
      sel(rss_pkg::ACCESS_HI_BANK, 8'h90);
      wr(rss_pkg::ADDR_FILE_DATA, 32'h0);
      wr(rss_pkg::ADDR_BANK, 32'h2);
      run(16'h6890);
      sel(rss_pkg::ACCESS_HI_BANK, 8'h90);
      rd(rss_pkg::ADDR_FILE_DATA);
      `CHK(rdat[7:0], 8'hff)
      // late ready on both answers: each must stand until taken
      wr(rss_pkg::ADDR_ACC, 32'h5a, 4'hf, 3);
      `CHK(resp, rss_pkg::RESP_OKAY)
      rd(rss_pkg::ADDR_ACC, 3);
      `CHK(rdat[7:0], 8'h5a)
      close_out();
   end
endmodule
